// ---- hw/pcs_core.sv ----
`timescale 1ns/1ps
// Behaviour
// - 13-bit counter, low byte read/write
// - upper bits unreadable, set via latch
// - any reset clears upper counter bits
// - low-byte write loads lower five latch bits into upper bits
// - jump/call: 11 instruction bits, latch page
// - 8K space in 2K branch pages
// - eight entry 13-bit return stack
// - stack hidden, pointer not software-visible
// - call pushes counter plus one, interrupt pushes counter
// - only the return operation pops the stack
// - push and pop leave latch alone
// - circular stack overwrites oldest entry
// - no overflow or underflow indication
// - return reloads all 13 bits from stack
module pcs_core (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire pcs_pkg::pcs_op_type op,
   input  wire logic [10:0]       branch_addr,
   input  wire logic [12:0]       vector_addr,
   input  wire logic [7:0]        low_wdata,
   input  wire logic              latch_we,
   input  wire logic [7:0]        latch_wdata,
   output logic [12:0]            pc,
   output logic [7:0]             pc_low_byte,
   output logic [7:0]             pc_high_latch
);
   logic [12:0]  pc_r;          // program counter
   logic [12:0]  pc_nxt;
   logic [7:0]   latch_r;       // high-byte latch
   logic [7:0]   latch_nxt;
   logic         push;          // stack strobes
   logic         pop;
   logic [12:0]  ret_addr;      // return address to push

   pcs_stack_if  stk ();

   // increment wraps inside 13 bits; used in two places
   function automatic logic [12:0] pcs_inc(input logic [12:0] v);
      pcs_inc = v + pcs_pkg::PC_ONE;
   endfunction : pcs_inc

   // counter next value, one operation per cycle
   always_comb begin
      pc_nxt   = pc_r;
      push     = 1'b0;
      pop      = 1'b0;
      ret_addr = pcs_inc(pc_r);
      case (op)
         pcs_pkg::PCS_OP_STEP: begin
            pc_nxt = pcs_inc(pc_r);
         end
         pcs_pkg::PCS_OP_JUMP: begin
            // page from latch, offset from instruction
            pc_nxt = {latch_r[pcs_pkg::PAGE_MSB:pcs_pkg::PAGE_LSB], branch_addr};
         end
         pcs_pkg::PCS_OP_CALL: begin
            push   = 1'b1;
            pc_nxt = {latch_r[pcs_pkg::PAGE_MSB:pcs_pkg::PAGE_LSB], branch_addr};
         end
         pcs_pkg::PCS_OP_RET: begin
            // full address from stack, latch page bits ignored
            pop    = 1'b1;
            pc_nxt = stk.rdata;
         end
         pcs_pkg::PCS_OP_IRQ: begin
            // interrupted instruction resumes at current counter
            push     = 1'b1;
            ret_addr = pc_r;
            pc_nxt   = vector_addr;
         end
         pcs_pkg::PCS_OP_LOWWR: begin
            // no carry from low byte: tables stay within a 256-word page
            pc_nxt = {latch_r[pcs_pkg::UP_W-1:0], low_wdata};
         end
         pcs_pkg::PCS_OP_HOLD: begin
            pc_nxt = pc_r;
         end
         default: begin
            pc_nxt = pc_r;
         end
      endcase
   end

   // latch changes only by its own write, never by stack traffic
   always_comb begin
      latch_nxt = latch_r;
      if (latch_we) begin
         latch_nxt = latch_wdata;
      end
   end

   // registers; reset clears the whole counter including upper bits
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pc_r    <= pcs_pkg::PC_RST;
         latch_r <= pcs_pkg::LATCH_RST;
      end else begin
         pc_r    <= pc_nxt;
         latch_r <= latch_nxt;
      end
   end

   assign stk.push  = push;
   assign stk.pop   = pop;
   assign stk.wdata = ret_addr;

   // stack memory, pointer private to it
   pcs_stack u_stack (
      .clock (clock),
      .rstn  (rstn),
      .st    (stk.mem)
   );

   // outputs straight from flip-flops; upper bits only on fetch address
   assign pc            = pc_r;
   assign pc_low_byte   = pc_r[pcs_pkg::LOW_W-1:0];
   assign pc_high_latch = latch_r;
endmodule : pcs_core

// ---- hw/pcs_pkg.sv ----
package pcs_pkg;
   localparam int PC_W         = 13;               // counter width
   localparam int LOW_W        = 8;                // software-visible low byte
   localparam int UP_W         = 5;                // upper counter bits
   localparam int BR_W         = 11;               // branch field width
   localparam int PAGE_LSB     = 3;                // latch bit for page low
   localparam int PAGE_MSB     = 4;                // latch bit for page high
   localparam int DEPTH        = 8;                // stack entries
   localparam int PTR_W        = 3;                // stack pointer width
   localparam int PROG_WORDS   = 8192;             // program space words
   localparam int PAGE_WORDS   = 2048;             // words per branch page
   localparam logic [12:0] PC_RST    = 13'h0000;   // counter after reset
   localparam logic [12:0] VECTOR_DEF = 13'h0004;  // default vector, arbitrary plain value
   localparam logic [2:0]  PTR_RST   = 3'h0;       // pointer after reset
   localparam logic [7:0]  LATCH_RST = 8'h00;      // latch after reset
   localparam logic [12:0] PC_ONE    = 13'h0001;   // sequential step

   // operation chosen by the decoder
   typedef enum logic [2:0] {
      PCS_OP_STEP,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_RET,
      PCS_OP_IRQ,
      PCS_OP_LOWWR,
      PCS_OP_HOLD
   } pcs_op_type;
endpackage : pcs_pkg

// ---- hw/pcs_stack.sv ----
`timescale 1ns/1ps
// circular return stack, no overflow status
module pcs_stack (
   input  wire logic clock,
   input  wire logic rstn,
   pcs_stack_if.mem  st
);
   logic [12:0]  mem_r [pcs_pkg::DEPTH];   // storage, outside program/data space
   logic [2:0]   ptr_r;                    // next free slot, hidden from software
   logic [2:0]   ptr_nxt;
   logic [12:0]  top_r;                    // registered top entry
   logic [12:0]  top_nxt;

   // pointer wraps silently, so a ninth push overwrites the first
   always_comb begin
      ptr_nxt = ptr_r;
      top_nxt = top_r;
      if (st.push) begin
         ptr_nxt = ptr_r + 3'h1;
         top_nxt = st.wdata;
      end else if (st.pop) begin
         ptr_nxt = ptr_r - 3'h1;
         top_nxt = mem_r[ptr_r - 3'h2];
      end
   end

   // storage itself has no reset; only pointer and top register do
   always_ff @(posedge clock) begin
      if (st.push) begin
         mem_r[ptr_r] <= st.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ptr_r <= pcs_pkg::PTR_RST;
         top_r <= pcs_pkg::PC_RST;
      end else begin
         ptr_r <= ptr_nxt;
         top_r <= top_nxt;
      end
   end

   assign st.rdata = top_r;
endmodule : pcs_stack

// ---- hw/pcs_stack_if.sv ----
`timescale 1ns/1ps
// push/pop port between counter and stack memory
interface pcs_stack_if;
   logic        push;    // write entry at pointer
   logic        pop;     // step pointer back and read
   logic [12:0] wdata;   // return address pushed
   logic [12:0] rdata;   // entry on top, registered
   modport ctl (output push, output pop, output wdata, input rdata);
   modport mem (input push, input pop, input wdata, output rdata);
endinterface : pcs_stack_if

// ---- verification/pcs_checker.sv ----
`timescale 1ns/1ps
// op codes by position: 0 step 1 jump 2 call 3 ret 4 irq 5 low write 6 hold
module pcs_checker (
   input wire logic              clock, rstn, latch_we,
   input wire pcs_pkg::pcs_op_type op,
   input wire logic [10:0]       branch_addr,
   input wire logic [12:0]       vector_addr, pc,
   input wire logic [7:0]        low_wdata, latch_wdata, pc_low_byte, pc_high_latch
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_low; pc_low_byte == pc[7:0]; endproperty
   a_low: assert property (p_low) else $error("low byte differs");
   property p_rst; !$past(rstn) |-> pc == 13'h0000 && pc_high_latch == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_step; op == 3'h0 |=> pc == 13'($past(pc) + 13'h0001); endproperty
   a_step: assert property (p_step) else $error("step wrong");
   property p_jmp;
      op inside {3'h1, 3'h2} |=> pc == {$past(pc_high_latch[4:3]), $past(branch_addr)};
   endproperty
   a_jmp: assert property (p_jmp) else $error("branch target wrong");
   property p_lw;
      op == 3'h5 |=> pc == {$past(pc_high_latch[4:0]), $past(low_wdata)};
   endproperty
   a_lw: assert property (p_lw) else $error("low write load wrong");
   property p_irq; op == 3'h4 |=> pc == $past(vector_addr); endproperty
   a_irq: assert property (p_irq) else $error("vector not taken");
   property p_lat; !latch_we |=> $stable(pc_high_latch); endproperty
   a_lat: assert property (p_lat) else $error("latch moved");
   property p_ret; op == 3'h2 ##1 op == 3'h3 |=> pc == 13'($past(pc, 2) + 13'h0001); endproperty
   a_ret: assert property (p_ret) else $error("return address wrong");
endmodule : pcs_checker
bind pcs_core pcs_checker i_pcs_checker (.clock, .rstn, .latch_we, .op, .branch_addr,
   .vector_addr, .pc, .low_wdata, .latch_wdata, .pc_low_byte, .pc_high_latch);

// ---- verification/pcs_core_bench.sv ----
`timescale 1ns/1ps
module pcs_core_bench;
   logic clock = 0, rstn = 0, latch_we, armed = 0;
   pcs_pkg::pcs_op_type op;
   logic [10:0] branch_addr;
   logic [12:0] vector_addr, pc, epc;
   logic [7:0]  low_wdata, latch_wdata, pc_low_byte, pc_high_latch, elat;
   logic [12:0] stk [8]; // expected stack, never cleared like the real one
   logic [2:0]  sp;
   int          errors = 0, checked = 0, cyc = 0;
   initial forever #20 clock = ~clock;
   pcs_core i_pcs_core (.clock, .rstn, .op, .branch_addr, .vector_addr, .low_wdata,
      .latch_we, .latch_wdata, .pc, .pc_low_byte, .pc_high_latch);
   pcs_decoder_model i_pcs_decoder_model (.clock, .op, .branch_addr, .vector_addr,
      .low_wdata, .latch_wdata, .latch_we);
   task automatic check(string n, logic [12:0] seen, logic [12:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   // cycle ceiling; a hang counts as a mismatch and ends in the report
   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         summarize();
      end
   end
   // reference counter: old outputs compared, then the taken op applied
   always @(posedge clock) begin
      if (armed) begin
         check("pc", pc, epc);
         check("low", {5'h0, pc_low_byte}, {5'h0, epc[7:0]});
         check("latch", {5'h0, pc_high_latch}, {5'h0, elat});
      end
      if (!rstn) begin
         epc = 13'h0000;
         elat = 8'h00;
         sp = 3'h0;
         armed = 1;
      end else begin
         case (3'(op))
            3'h0: epc = epc + 13'h0001;
            3'h1: epc = {elat[4:3], branch_addr};
            3'h2: begin stk[sp] = epc + 13'h0001; sp++; epc = {elat[4:3], branch_addr}; end
            3'h3: begin sp--; epc = stk[sp]; end
            3'h4: begin stk[sp] = epc; sp++; epc = vector_addr; end
            3'h5: epc = {elat[4:0], low_wdata};
            default: ;
         endcase
         if (latch_we) elat = latch_wdata; // op this edge used the old latch
      end
   end
   task automatic go(logic [2:0] o, logic [7:0] w = 8'h00, logic we = 1'b0, logic [7:0] lw = 8'h00);
      i_pcs_decoder_model.issue(o, 11'($urandom), 13'($urandom), w, we, lw);
   endtask : go
   initial begin
      void'($urandom(72651));
      repeat (5) @(posedge clock);
      rstn <= 1;
      go(3'h6, 8'h00, 1, 8'hff); // top page, then wrap past the last word
      go(3'h5, 8'hff);
      go(3'h0);
      go(3'h0);
      go(3'h6, 8'h00, 1, 8'h18); // page 3 for branches
      repeat (9) go(3'h2); // ninth call overwrites the first slot
      repeat (10) go(3'h3); // one pop more than the calls
      go(3'h4);
      go(3'h3);
      repeat (2000) go(3'($urandom_range(0, 6)), 8'($urandom), 1'($urandom), 8'($urandom));
      go(3'h6, 8'h00, 1, 8'hff);
      go(3'h6); // latch write dropped before reset, so release shows a clean latch
      rstn <= 0; // mid-run reset with latch and counter nonzero
      repeat (5) @(posedge clock);
      rstn <= 1;
      go(3'h0);
      repeat (3) go(3'h6);
      repeat (3) @(posedge clock); // let the last ops reach the reference compare
      @(negedge clock);
      summarize();
   end
endmodule : pcs_core_bench

// ---- verification/pcs_decoder_model.sv ----
`timescale 1ns/1ps
// decoder stand-in: one op per edge, fields held for that whole cycle
module pcs_decoder_model (
   input  wire logic clock,
   output pcs_pkg::pcs_op_type op,
   output logic [10:0] branch_addr,
   output logic [12:0] vector_addr,
   output logic [7:0]  low_wdata, latch_wdata,
   output logic        latch_we
);
   initial op = pcs_pkg::PCS_OP_HOLD;
   initial {branch_addr, vector_addr, low_wdata, latch_we, latch_wdata} = '0;
   task automatic issue(logic [2:0] o, logic [10:0] b, logic [12:0] v,
                        logic [7:0] w, logic we, logic [7:0] lw);
      @(posedge clock);
      op <= pcs_pkg::pcs_op_type'(o);
      branch_addr <= b;
      vector_addr <= v;
      low_wdata <= w; // offsets stay within one 256 block, no carry wanted
      latch_we <= we;
      latch_wdata <= lw;
   endtask : issue
endmodule : pcs_decoder_model
